/* verilog/rtc_ctrl.v */
`timescale 1ns/1ps
`include "rtc_ctrl_defs.vh"

// Operation
// RULE1: recovery select is bit 7 at 04h
// RULE2: writes blocked through recovery interval
// RULE3: interval chosen by select and stop bits
// RULE4: fixed read-only 8-byte serial number
// RULE5: oscillator stop sets fail flag
// RULE6: flag with enable drives interrupt pin
// RULE7: flag/enable clear or reset release interrupt
// RULE8: fail flag sticky until written zero
// RULE9: host waits 4 s before clearing flag; rtc_host clr_flag waits SETTLE = 20 clocks
// RULE10: detection works on battery too
// RULE11: backup drives pin only with enable
// RULE12: century leap only when both bits zero
// RULE13: initial power-up default values
// RULE14: battery power-up keeps or clears bits
// RULE15: tamper enable blocks halt on power-down
// RULE16: 32 kHz output only on main supply
// RULE17: reset low during fail and recovery
// RULE18: power-on reset clears enables; tamper_enable is kept or cleared and khz_output_enable is kept or set to one
// RULE19: interrupt follows flag combination promptly
module rtc_ctrl #(
  parameter [31:0]  DEF_CYCLES  = `T_REC_DEF_MS * 1000 * `CLK_MHZ,
  parameter [31:0]  STOP_CYCLES = `T_REC_STOP_MS * 1000 * `CLK_MHZ,
  parameter [31:0]  FAST_CYCLES = `T_REC_FAST_US * `CLK_MHZ,
  parameter [63:0]  SERIAL_NUM  = 64'h0123456789ABCDEF // arbitrary value
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Power state
  input  wire        supply_ok,
  input  wire        battery_ok,
  input  wire        osc_running,
  // Register port
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [7:0]  addr,
  input  wire [7:0]  wr_data,
  output reg  [7:0]  rd_data,
  // Calendar
  input  wire [7:0]  year_bcd,
  output reg         leap_year,
  // Pins
  output reg         irq_out_n,
  output reg         rst_out_n,
  output reg         khz_out_en
);

  // Control bits
  reg        recovery_time_select;
  reg        osc_stop;
  reg        osc_fail_flag;
  reg        osc_fail_irq_enable;
  reg        halt_update;
  reg        out_bit;
  reg        freq_test;
  reg        alarm_flag_enable;
  reg        backup_irq_enable;
  reg        square_wave_enable;
  reg        square_wave_open_drain;
  reg        powerfail_open_drain;
  reg        khz_output_enable;
  reg        threshold_select;
  reg        tamper_enable;
  reg        tamper_irq_enable;
  reg  [6:0] watchdog_steering;
  reg  [4:0] day_bits;
  reg        century_bit_lo;
  reg        century_bit_hi;
  reg        initialised;
  reg        supply_d;
  wire       rec_busy;
  wire       wr_ok;
  wire       irq_act;
  wire [1:0] cent;

  // ==========================================================
  // Recovery timer
  recovery_timer #(
    .DEF_CYCLES  (DEF_CYCLES),
    .STOP_CYCLES (STOP_CYCLES),
    .FAST_CYCLES (FAST_CYCLES)
  ) u_rec (
    .clk       (clk),
    .reset     (reset),
    .supply_ok (supply_ok),
    .rec_sel   (recovery_time_select),
    .stop      (osc_stop),
    .busy_reg  (rec_busy)
  );

  // Writes only outside deselect and recovery
  assign wr_ok = wr_en && supply_ok && !rec_busy; // RULE2

  // ==========================================================
  // Control registers and power transitions
  always @(posedge clk)
  begin
    supply_d <= supply_ok;
    // Marker powers up unknown: anything but a settled one is first power
    if (reset && (initialised !== 1'b1))
    begin
      // First power application
      recovery_time_select   <= 1'b0; // RULE13
      osc_stop               <= 1'b0;
      osc_fail_flag          <= 1'b1; // RULE5
      osc_fail_irq_enable    <= 1'b0;
      halt_update            <= 1'b1;
      out_bit                <= 1'b1;
      freq_test              <= 1'b0;
      alarm_flag_enable      <= 1'b0;
      backup_irq_enable      <= 1'b0;
      square_wave_enable     <= 1'b0;
      square_wave_open_drain <= 1'b1;
      powerfail_open_drain   <= 1'b1;
      khz_output_enable      <= 1'b1;
      threshold_select       <= 1'b0;
      tamper_enable          <= 1'b0;
      tamper_irq_enable      <= 1'b0;
      watchdog_steering      <= 7'h00;
      day_bits               <= 5'h00;
      century_bit_lo         <= 1'b0;
      century_bit_hi         <= 1'b0;
      initialised            <= 1'b1;
    end
    else if (reset || (supply_ok && !supply_d))
    begin
      // Battery-backed power-up: other bits unchanged
      osc_fail_irq_enable <= 1'b0; // RULE14 RULE18
      freq_test           <= 1'b0;
      alarm_flag_enable   <= 1'b0;
      backup_irq_enable   <= 1'b0;
      square_wave_enable  <= 1'b0;
      watchdog_steering   <= 7'h00;
      tamper_irq_enable   <= 1'b0;
      if (!tamper_enable)
        halt_update <= 1'b1; // RULE14 RULE15
      if (!osc_running)
        osc_fail_flag <= 1'b1; // RULE10
    end
    else
    begin
      // Power-down sets halt unless tamper owns the timestamp
      if (!supply_ok && supply_d && !tamper_enable)
        halt_update <= 1'b1; // RULE15
      if (wr_ok)
      begin
        if (addr == `ADDR_DAY_REC)
        begin
          recovery_time_select <= wr_data[`BIT_REC_SEL]; // RULE1
          century_bit_hi       <= wr_data[`BIT_CB_HI];
          century_bit_lo       <= wr_data[`BIT_CB_LO];
          day_bits             <= wr_data[4:0];
        end
        else if (addr == `ADDR_CTRL)
        begin
          out_bit   <= wr_data[`BIT_OUT];
          freq_test <= wr_data[`BIT_FT];
        end
        else if (addr == `ADDR_ALARM)
        begin
          alarm_flag_enable  <= wr_data[`BIT_AFE];
          square_wave_enable <= wr_data[`BIT_SQUARE_WAVE_ENABLE];
          backup_irq_enable  <= wr_data[`BIT_ABE];
        end
        else if (addr == `ADDR_WDOG)
          watchdog_steering <= wr_data[6:0];
        else if (addr == `ADDR_TAMPER)
        begin
          tamper_enable          <= wr_data[`BIT_TEB];
          tamper_irq_enable      <= wr_data[`BIT_TIE];
          square_wave_open_drain <= wr_data[`BIT_SQUARE_WAVE_OPEN_DRAIN];
          powerfail_open_drain   <= wr_data[`BIT_POWERFAIL_OPEN_DRAIN];
          khz_output_enable      <= wr_data[`BIT_KHZ];
          threshold_select       <= wr_data[`BIT_THS];
        end
        else if (addr == `ADDR_STOP)
          osc_stop <= wr_data[`BIT_STOP];
        else if (addr == `ADDR_FLAGS)
        begin
          osc_fail_irq_enable <= wr_data[`BIT_OSC_FAIL_IRQ_ENABLE];
          halt_update         <= wr_data[`BIT_HT];
        end
        // Serial number addresses ignore writes
      end
      // Set beats host clear; never cleared by oscillator recovery
      if (!osc_running || osc_stop || (wr_ok && addr == `ADDR_STOP && wr_data[`BIT_STOP]))
        osc_fail_flag <= 1'b1; // RULE5 RULE8
      else if (wr_ok && addr == `ADDR_FLAGS && !wr_data[`BIT_OF])
        osc_fail_flag <= 1'b0; // RULE8 RULE9
    end
  end

  // ==========================================================
  // Interrupt and pin outputs
  assign irq_act = osc_fail_flag && osc_fail_irq_enable; // RULE6 RULE19
  assign cent    = {century_bit_hi, century_bit_lo};

  always @(posedge clk)
  begin
    if (reset)
    begin
      irq_out_n  <= 1'b1;
      rst_out_n  <= 1'b0;
      khz_out_en <= 1'b0;
      leap_year  <= 1'b0;
    end
    else
    begin
      rst_out_n <= supply_ok && !rec_busy; // RULE17
      // Released while reset output is active, except on battery with backup_irq_enable set
      if (!supply_ok || rec_busy)
        irq_out_n <= !(!supply_ok && battery_ok
                       && backup_irq_enable && irq_act); // RULE7 RULE11
      else if (irq_act)
        irq_out_n <= 1'b0; // RULE6
      else
        irq_out_n <= out_bit;
      khz_out_en <= supply_ok && khz_output_enable && !osc_stop; // RULE16
      // Year 00 leaps only in the first century code
      if (year_bcd == 8'h00)
        leap_year <= (cent == 2'b00); // RULE12
      else
        leap_year <= (year_bcd[4] ? (year_bcd[3:0] == 4'h2 || year_bcd[3:0] == 4'h6)
                     : (year_bcd[3:0] == 4'h0 || year_bcd[3:0] == 4'h4
                        || year_bcd[3:0] == 4'h8)) ^ 1'b0;
    end
  end

  // ==========================================================
  // Register read
  always @(posedge clk)
  begin
    if (reset)
      rd_data <= 8'h00;
    else if (rd_en)
    begin
      if (addr == `ADDR_DAY_REC)
        rd_data <= {recovery_time_select, century_bit_hi, century_bit_lo, day_bits};
      else if (addr == `ADDR_FLAGS)
        rd_data <= {osc_fail_irq_enable, halt_update, 3'b000, osc_fail_flag, 2'b00};
      else if (addr == `ADDR_STOP)
        rd_data <= {osc_stop, 7'h00};
      else if (addr == `ADDR_CTRL)
        rd_data <= {out_bit, freq_test, 6'h00};
      else if (addr == `ADDR_ALARM)
        rd_data <= {alarm_flag_enable, square_wave_enable, backup_irq_enable, 5'h00};
      else if (addr == `ADDR_WDOG)
        rd_data <= {1'b0, watchdog_steering};
      else if (addr == `ADDR_TAMPER)
        rd_data <= {tamper_enable, tamper_irq_enable, 1'b0, square_wave_open_drain,
                    powerfail_open_drain, khz_output_enable, threshold_select, 1'b0};
      else if ((addr & 8'hF8) == `ADDR_SERIAL_BASE)
        rd_data <= SERIAL_NUM[{addr[2:0], 3'b000} +: 8]; // RULE4
      else
        rd_data <= 8'h00;
    end
  end

endmodule

/* verilog/rtc_ctrl_defs.vh */
`ifndef RTC_CTRL_DEFS_VH
`define RTC_CTRL_DEFS_VH

// ==========================================================
// Register addresses
`define ADDR_DAY_REC     8'h04
`define ADDR_STOP        8'h01
`define ADDR_FLAGS       8'h0F
`define ADDR_CTRL        8'h08
`define ADDR_ALARM       8'h0A
`define ADDR_WDOG        8'h09
`define ADDR_TAMPER      8'h14
`define ADDR_SERIAL_BASE 8'h18

// ==========================================================
// Field positions
`define BIT_REC_SEL      7
`define BIT_STOP         7
`define BIT_OF           2
`define BIT_OSC_FAIL_IRQ_ENABLE         7
`define BIT_HT           6
`define BIT_OUT          7
`define BIT_FT           6
`define BIT_AFE          7
`define BIT_ABE          5
`define BIT_SQUARE_WAVE_ENABLE         6
`define BIT_SQUARE_WAVE_OPEN_DRAIN        4
`define BIT_POWERFAIL_OPEN_DRAIN         3
`define BIT_KHZ          2
`define BIT_THS          1
`define BIT_TEB          7
`define BIT_TIE          6
`define BIT_CB_LO        5
`define BIT_CB_HI        6

// ==========================================================
// Recovery times, in their printed units
`define T_REC_DEF_MS     96
`define T_REC_STOP_MS    40
`define T_REC_FAST_US    50
`define CLK_MHZ          200

`endif

/* verilog/recovery_timer.v */
`timescale 1ns/1ps
`include "rtc_ctrl_defs.vh"

// Counts the write-deselect recovery interval after supply return
module recovery_timer #(
  parameter [31:0] DEF_CYCLES  = `T_REC_DEF_MS * 1000 * `CLK_MHZ,
  parameter [31:0] STOP_CYCLES = `T_REC_STOP_MS * 1000 * `CLK_MHZ,
  parameter [31:0] FAST_CYCLES = `T_REC_FAST_US * `CLK_MHZ
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Control
  input  wire        supply_ok,
  input  wire        rec_sel,
  input  wire        stop,
  // Status
  output reg         busy_reg
);

  reg  [31:0] count_reg;
  wire [31:0] limit;

  // ==========================================================
  // Interval selection
  assign limit = rec_sel ? FAST_CYCLES : (stop ? STOP_CYCLES : DEF_CYCLES); // RULE3

  // ==========================================================
  // Busy while supply low, then for the selected interval
  always @(posedge clk)
  begin
    if (reset || !supply_ok)
    begin
      count_reg <= 32'h00000000;
      busy_reg  <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (count_reg >= limit - 32'h00000001)
        busy_reg <= 1'b0; // RULE2
      count_reg <= count_reg + 32'h00000001;
    end
  end

endmodule

/* test/rtc_host.sv */
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module rtc_host #(
  parameter SETTLE = 20
)
(
  // Clock
  input  wire       clk,
  // Register port
  output reg        wr_en,
  output reg        rd_en,
  output reg  [7:0] addr,
  output reg  [7:0] wr_data,
  input  wire [7:0] rd_data
);
  // Idle bus at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // One write, strobe held for one edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      addr <= ~a; // No stale value once released
      wr_data <= ~d;
    end
  endtask
  // One read, data taken one cycle on
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      addr <= ~a;
      #1;
      d = rd_data;
    end
  endtask
  // Let the oscillator settle before clearing the flag
  task clr_flag(input [7:0] keep);
    begin
      repeat (SETTLE) @(posedge clk);
      wr(8'h0F, keep);
    end
  endtask
endmodule

/* test/rtc_ctrl_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker
module rtc_ctrl_checker #(
  parameter [63:0] SERIAL_NUM = 64'h0
)
(
  // Clock and reset
  input wire       clk,
  input wire       reset,
  // Observed ports
  input wire       supply_ok,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] addr,
  input wire [7:0] rd_data,
  input wire [7:0] year_bcd,
  input wire       leap_year,
  input wire       irq_out_n,
  input wire       rst_out_n,
  input wire       khz_out_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_khz; !supply_ok [*2] |-> !khz_out_en; endproperty
  a_khz: assert property (p_khz) else $error("khz on battery");
  property p_rst; !supply_ok [*2] |-> !rst_out_n; endproperty
  a_rst: assert property (p_rst) else $error("rst high on fail");
  // Shortest interval still outlasts eight cycles
  property p_hold; $rose(supply_ok) |-> !rst_out_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("recovery short");
  property p_quiet; (supply_ok && !rst_out_n) [*2] |-> irq_out_n; endproperty
  a_quiet: assert property (p_quiet) else $error("irq in reset");
  property p_keep;
    (!irq_out_n && rd_en && !wr_en && supply_ok && rst_out_n) |=> !irq_out_n;
  endproperty
  a_keep: assert property (p_keep) else $error("read cleared irq");
  property p_sn0; (rd_en && addr == 8'h18) |=> rd_data == SERIAL_NUM[7:0]; endproperty
  a_sn0: assert property (p_sn0) else $error("serial lo");
  property p_sn7; (rd_en && addr == 8'h1F) |=> rd_data == SERIAL_NUM[63:56]; endproperty
  a_sn7: assert property (p_sn7) else $error("serial hi");
  property p_lp4; (year_bcd == 8'h04) [*2] |-> leap_year; endproperty
  a_lp4: assert property (p_lp4) else $error("leap 04");
  property p_lp1; (year_bcd == 8'h01) [*2] |-> !leap_year; endproperty
  a_lp1: assert property (p_lp1) else $error("leap 01");
endmodule

bind rtc_ctrl rtc_ctrl_checker #(.SERIAL_NUM(SERIAL_NUM)) u_rtc_ctrl_checker (
  .clk(clk), .reset(reset), .supply_ok(supply_ok), .wr_en(wr_en),
  .rd_en(rd_en), .addr(addr), .rd_data(rd_data), .year_bcd(year_bcd),
  .leap_year(leap_year), .irq_out_n(irq_out_n), .rst_out_n(rst_out_n),
  .khz_out_en(khz_out_en));

/* test/rtc_osc_fail_and_power_defaults_tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// Bench top
module rtc_osc_fail_and_power_defaults_tb_top;
  localparam [63:0] SN = 64'h5A3C96F00F1E2D4B; // Arbitrary value
  reg        clk, reset, supply_ok, battery_ok, osc_running;
  reg  [7:0] year_bcd;
  wire       wr_en, rd_en, leap_year, irq_out_n, rst_out_n, khz_out_en;
  wire [7:0] addr, wr_data, rd_data;
  logic[7:0] d;
  integer    n_fail, checks_done, i;
  always #2.5 clk = ~clk;
  rtc_host u_rtc_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data));
  rtc_ctrl #(.DEF_CYCLES(32'h64), .STOP_CYCLES(32'h28), .FAST_CYCLES(32'h0A),
    .SERIAL_NUM(SN)) u_rtc_ctrl (.clk(clk), .reset(reset),
    .supply_ok(supply_ok), .battery_ok(battery_ok), .osc_running(osc_running),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .year_bcd(year_bcd), .leap_year(leap_year),
    .irq_out_n(irq_out_n), .rst_out_n(rst_out_n), .khz_out_en(khz_out_en));
  task chk(input logic [63:0] s, input logic [63:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e)
      begin
        n_fail = n_fail + 1;
        $display("ERROR %0t saw %h want %h", $time, s, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task w2;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // Count cycles until reset output releases; bounded
  task rec(input integer n);
    integer c;
    begin
      c = 0;
      while (!rst_out_n && c < 400)
      begin
        @(posedge clk);
        #1;
        c = c + 1;
      end
      if (c >= 400)
      begin
        n_fail = n_fail + 1;
        test_done;
      end
      else
        chk(c >= n - 3 && c <= n + 3, 1'b1);
    end
  endtask
  task down;
    begin
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (4) @(posedge clk);
      supply_ok <= 1'b1;
    end
  endtask
  task t_init;
    begin
      rec(100);
      u_rtc_host.rd(8'h0F, d);
      chk(d & 8'hC4, 8'h44);
      u_rtc_host.rd(8'h08, d);
      chk(d & 8'hC0, 8'h80);
      u_rtc_host.rd(8'h0A, d);
      chk(d & 8'hE0, 8'h00);
      u_rtc_host.rd(8'h04, d);
      chk(d[7], 1'b0);
      chk(khz_out_en, 1'b1);
      $display("t_init done");
    end
  endtask
  task t_irq;
    begin
      u_rtc_host.wr(8'h0F, 8'h84);
      w2;
      chk(irq_out_n, 1'b0);
      u_rtc_host.rd(8'h0F, d);
      chk(irq_out_n, 1'b0);
      u_rtc_host.clr_flag(8'h80);
      w2;
      chk(irq_out_n, 1'b1);
      @(posedge clk);
      osc_running <= 1'b0;
      w2;
      chk(irq_out_n, 1'b0);
      @(posedge clk);
      osc_running <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk(irq_out_n, 1'b0);
      u_rtc_host.wr(8'h0F, 8'h04);
      w2;
      chk(irq_out_n, 1'b1);
      $display("t_irq done");
    end
  endtask
  task t_serial;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        u_rtc_host.rd(8'h18 + i[7:0], d);
        chk(d, SN[8*i +: 8]);
      end
      u_rtc_host.wr(8'h18, ~SN[7:0]);
      u_rtc_host.rd(8'h18, d);
      chk(d, SN[7:0]);
      $display("t_serial done");
    end
  endtask
  task t_rec;
    begin
      u_rtc_host.wr(8'h04, 8'h80);
      down;
      rec(10);
      u_rtc_host.rd(8'h04, d);
      chk(d[7], 1'b1);
      u_rtc_host.wr(8'h04, 8'h00);
      u_rtc_host.wr(8'h01, 8'h80);
      down;
      rec(40);
      u_rtc_host.rd(8'h0F, d);
      chk(d[2], 1'b1);
      u_rtc_host.wr(8'h01, 8'h00);
      down;
      u_rtc_host.wr(8'h04, 8'h80);
      rec(98);
      u_rtc_host.rd(8'h04, d);
      chk(d[7], 1'b0);
      $display("t_rec done");
    end
  endtask
  task t_batt;
    begin
      u_rtc_host.wr(8'h04, 8'h80);
      u_rtc_host.wr(8'h08, 8'hC0);
      u_rtc_host.wr(8'h0F, 8'h84);
      u_rtc_host.wr(8'h0A, 8'h00);
      @(posedge clk);
      supply_ok <= 1'b0;
      w2;
      chk(irq_out_n, 1'b1);
      chk(khz_out_en, 1'b0);
      @(posedge clk);
      supply_ok <= 1'b1;
      rec(10);
      u_rtc_host.wr(8'h0A, 8'hE0);
      reset <= 1'b1;
      w2;
      @(posedge clk);
      reset <= 1'b0;
      rec(10);
      u_rtc_host.rd(8'h0F, d);
      chk(d & 8'hC4, 8'h44);
      u_rtc_host.rd(8'h08, d);
      chk(d & 8'hC0, 8'h80);
      u_rtc_host.rd(8'h0A, d);
      chk(d & 8'hE0, 8'h00);
      u_rtc_host.rd(8'h04, d);
      chk(d[7], 1'b1);
      $display("t_batt done");
    end
  endtask
  // Tamper keeps halt clear; a stop while down still flags
  task t_tamp;
    begin
      u_rtc_host.wr(8'h14, 8'hDC);
      u_rtc_host.clr_flag(8'h00);
      u_rtc_host.rd(8'h0F, d);
      chk(d[2], 1'b0);
      @(posedge clk);
      supply_ok <= 1'b0;
      @(posedge clk);
      osc_running <= 1'b0;
      repeat (2) @(posedge clk);
      osc_running <= 1'b1;
      @(posedge clk);
      supply_ok <= 1'b1;
      rec(10);
      u_rtc_host.rd(8'h0F, d);
      chk(d[6], 1'b0);
      chk(d[2], 1'b1);
      u_rtc_host.rd(8'h14, d);
      chk(d, 8'h9C);
      $display("t_tamp done");
    end
  endtask
  task yr(input [7:0] y, input e);
    begin
      @(posedge clk);
      year_bcd <= y;
      w2;
      chk(leap_year, e);
    end
  endtask
  task t_leap;
    begin
      yr(8'h00, 1'b1);
      yr(8'h01, 1'b0);
      yr(8'h04, 1'b1);
      yr(8'h96, 1'b1);
      yr(8'h10, 1'b0);
      u_rtc_host.wr(8'h04, 8'h40);
      yr(8'h00, 1'b0);
      $display("t_leap done");
    end
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    supply_ok = 1'b1;
    battery_ok = 1'b1;
    osc_running = 1'b1;
    year_bcd = 8'h00;
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_init;
    t_irq;
    t_serial;
    t_rec;
    t_batt;
    t_tamp;
    t_leap;
    test_done;
  end
endmodule
